//--- rtl/rdw_top.sv
// reset hold-off timer and watchdog with its prescaler
`timescale 1ns/100ps

module rdw_top #(
  parameter int HOLD_LONG_TICKS  = rdw_pkg::HOLD_LONG_TICKS,
  parameter int HOLD_POR_TICKS   = rdw_pkg::HOLD_POR_TICKS,
  parameter int HOLD_SHORT_TICKS = rdw_pkg::HOLD_SHORT_TICKS,
  parameter int WDT_BASE_TICKS   = rdw_pkg::WDT_BASE_TICKS
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 external_reset_pin,
  input  wire rdw_pkg::rdw_osc_t    osc_mode,
  input  wire logic                 watchdog_enable_fuse,
  input  wire rdw_pkg::rdw_option_t option,
  input  wire rdw_pkg::rdw_core_op_t core_op,
  input  wire logic                 wake_pin_change,
  input  wire logic                 wake_comparator_change,
  output logic                      core_reset,
  output logic                      sleep_active,
  output logic                      timeout_flag_n
);
  localparam logic [rdw_pkg::CNT_W-1:0] LONG_LOAD  = rdw_pkg::CNT_W'(HOLD_LONG_TICKS - 1);
  localparam logic [rdw_pkg::CNT_W-1:0] POR_LOAD   = rdw_pkg::CNT_W'(HOLD_POR_TICKS - 1);
  localparam logic [rdw_pkg::CNT_W-1:0] SHORT_LOAD = rdw_pkg::CNT_W'(HOLD_SHORT_TICKS - 1);
  localparam logic [rdw_pkg::CNT_W-1:0] WDT_LAST   = rdw_pkg::CNT_W'(WDT_BASE_TICKS - 1);
  localparam logic [rdw_pkg::DIV_W-1:0] DIV_LAST   = rdw_pkg::DIV_W'(rdw_pkg::RC_TICK_CYC - 1);
  localparam logic [rdw_pkg::CNT_W-1:0] CNT_ZERO   = '0;
  localparam logic [rdw_pkg::CNT_W-1:0] CNT_ONE    = rdw_pkg::CNT_W'(1);
  localparam logic [rdw_pkg::PRE_W-1:0] PRE_ONE    = rdw_pkg::PRE_W'(1);
  localparam int                        TICK_GAP   = rdw_pkg::RC_TICK_CYC;

  logic                       pin_s1;
  logic                       pin_s2;
  logic                       pin_s3;
  logic                       pin_level;
  logic [rdw_pkg::DIV_W-1:0]  div_cnt;
  logic                       rc_tick;
  rdw_pkg::rdw_state_t        state;
  rdw_pkg::rdw_state_t        next_state;
  logic [rdw_pkg::CNT_W-1:0]  hold_cnt;
  logic                       por_pend;
  logic [rdw_pkg::PRE_W-1:0]  pre_cnt;
  logic [rdw_pkg::CNT_W-1:0]  wdt_cnt;
  logic                       wdt_run;
  logic                       wdt_clear;
  logic                       base_tick;
  logic                       wdt_expire;
  logic                       hold_enter;

  // crystal modes need the long settle on every reset
  function automatic logic [rdw_pkg::CNT_W-1:0] hold_load(
    input rdw_pkg::rdw_osc_t mode,
    input logic              first
  );
    if (mode == rdw_pkg::OSC_FAST_CRYSTAL || mode == rdw_pkg::OSC_STANDARD_CRYSTAL ||
        mode == rdw_pkg::OSC_LOW_POWER_CRYSTAL) begin
      return LONG_LOAD;
    end else if (first) begin
      return POR_LOAD;
    end else begin
      return SHORT_LOAD;
    end
  endfunction

  function automatic logic [rdw_pkg::PRE_W-1:0] ratio_mask(input logic [rdw_pkg::PS_W-1:0] sel);
    return rdw_pkg::PRE_W'((8'h01 << sel) - 8'h01);
  endfunction

  // pin synchroniser, a level counts once the last two stages agree
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_s1 <= rdw_pkg::PIN_LEVEL_RST;
      pin_s2 <= rdw_pkg::PIN_LEVEL_RST;
      pin_s3 <= rdw_pkg::PIN_LEVEL_RST;
    end else begin
      pin_s1 <= external_reset_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_level <= rdw_pkg::PIN_LEVEL_RST;
    end else if (pin_s2 == pin_s3) begin
      pin_level <= pin_s3;
    end
  end

  // rc oscillator stand-in: free-running, ignores sleep and core state
  always_ff @(posedge core_clk) begin
    if (reset || div_cnt == DIV_LAST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + rdw_pkg::DIV_W'(1);
    end
  end

  assign rc_tick = (div_cnt == DIV_LAST);

  always_comb begin
    next_state = state;
    if (!pin_level) begin
      next_state = rdw_pkg::ST_PIN;
    end else begin
      case (state)
        rdw_pkg::ST_PIN: begin
          next_state = rdw_pkg::ST_HOLD;
        end
        rdw_pkg::ST_HOLD: begin
          if (rc_tick && hold_cnt == CNT_ZERO) begin
            next_state = rdw_pkg::ST_RUN;
          end
        end
        rdw_pkg::ST_RUN: begin
          if (wdt_expire) begin
            next_state = rdw_pkg::ST_HOLD;
          end else if (core_op.sleep_instruction) begin
            next_state = rdw_pkg::ST_SLEEP;
          end
        end
        rdw_pkg::ST_SLEEP: begin
          if (wdt_expire || wake_pin_change || wake_comparator_change) begin
            next_state = rdw_pkg::ST_HOLD;
          end
        end
        default: begin
          next_state = rdw_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // reset lands in the pin state so the first hold-off load sees the mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= rdw_pkg::ST_PIN;
    end else begin
      state <= next_state;
    end
  end

  assign hold_enter = (next_state == rdw_pkg::ST_HOLD) && (state != rdw_pkg::ST_HOLD);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      hold_cnt <= '0;
    end else if (hold_enter) begin
      hold_cnt <= hold_load(osc_mode, por_pend);
    end else if (state == rdw_pkg::ST_HOLD && rc_tick && hold_cnt != CNT_ZERO) begin
      hold_cnt <= hold_cnt - CNT_ONE;
    end
  end

  // a pin reset during the power-on hold-off keeps the power-on length
  always_ff @(posedge core_clk) begin
    if (reset) begin
      por_pend <= rdw_pkg::POR_PEND_RST;
    end else if (state == rdw_pkg::ST_HOLD && next_state == rdw_pkg::ST_RUN) begin
      por_pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      core_reset   <= 1'b1;
      sleep_active <= 1'b0;
    end else begin
      core_reset   <= (next_state == rdw_pkg::ST_HOLD) || (next_state == rdw_pkg::ST_PIN);
      sleep_active <= (next_state == rdw_pkg::ST_SLEEP);
    end
  end

  assign wdt_run   = watchdog_enable_fuse &&
                     (state == rdw_pkg::ST_RUN || state == rdw_pkg::ST_SLEEP);
  assign wdt_clear = (state == rdw_pkg::ST_RUN) &&
                     (core_op.clear_watchdog_instruction || core_op.sleep_instruction);
  assign base_tick = rc_tick && (!option.prescaler_to_watchdog ||
                     (pre_cnt & ratio_mask(option.ratio_sel)) == ratio_mask(option.ratio_sel));
  // a clear in the expiry cycle is too late; the time-out still fires
  assign wdt_expire = wdt_run && base_tick && (wdt_cnt == WDT_LAST);

  always_ff @(posedge core_clk) begin
    if (reset || !wdt_run) begin
      pre_cnt <= '0;
    end else if (wdt_clear && option.prescaler_to_watchdog) begin
      pre_cnt <= '0;
    end else if (rc_tick && option.prescaler_to_watchdog) begin
      pre_cnt <= pre_cnt + PRE_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || !wdt_run || wdt_expire) begin
      wdt_cnt <= '0;
    end else if (wdt_clear) begin
      wdt_cnt <= '0;
    end else if (base_tick) begin
      wdt_cnt <= wdt_cnt + CNT_ONE;
    end
  end

  // the flag survives pin resets; a time-out beats a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      timeout_flag_n <= rdw_pkg::TIMEOUT_FLAG_RST;
    end else if (wdt_expire) begin
      timeout_flag_n <= 1'b0;
    end else if (wdt_clear) begin
      timeout_flag_n <= 1'b1;
    end
  end

  a_hold_keeps_reset: assert property (@(posedge core_clk) disable iff (reset)
    state == rdw_pkg::ST_HOLD |-> core_reset)
    else $error("core not held in reset during hold-off");

  a_release_after_zero: assert property (@(posedge core_clk) disable iff (reset)
    $fell(core_reset) |-> $past(state) == rdw_pkg::ST_HOLD && $past(hold_cnt) == CNT_ZERO && $past(rc_tick))
    else $error("core released before hold-off expired");

  a_pin_low_reset: assert property (@(posedge core_clk) disable iff (reset)
    !pin_level |=> core_reset ##1 state == rdw_pkg::ST_PIN || pin_level)
    else $error("low reset pin did not hold the core");

  a_hold_tick_only: assert property (@(posedge core_clk) disable iff (reset)
    state == rdw_pkg::ST_HOLD && $past(state) == rdw_pkg::ST_HOLD && $changed(hold_cnt) |-> $past(rc_tick))
    else $error("hold-off counted without an rc tick");

  a_hold_load_val: assert property (@(posedge core_clk) disable iff (reset)
    hold_enter |=> hold_cnt == hold_load($past(osc_mode), $past(por_pend)))
    else $error("wrong hold-off length loaded");

  a_expire_resets: assert property (@(posedge core_clk) disable iff (reset)
    wdt_expire |=> core_reset && wdt_cnt == CNT_ZERO)
    else $error("watchdog time-out did not reset the device");

  a_sleep_wake_hold: assert property (@(posedge core_clk) disable iff (reset)
    state == rdw_pkg::ST_SLEEP && pin_level && (wdt_expire || wake_pin_change || wake_comparator_change)
    |=> state == rdw_pkg::ST_HOLD)
    else $error("sleep wake-up did not restart the hold-off");

  a_flag_cleared: assert property (@(posedge core_clk) disable iff (reset)
    wdt_expire |=> !timeout_flag_n)
    else $error("time-out flag not cleared on watchdog reset");

  a_fuse_off: assert property (@(posedge core_clk) disable iff (reset)
    !watchdog_enable_fuse |-> !wdt_expire ##1 (wdt_cnt == CNT_ZERO && pre_cnt == '0))
    else $error("watchdog active with fuse off");

  a_clear_zeroes: assert property (@(posedge core_clk) disable iff (reset)
    wdt_clear && !wdt_expire && option.prescaler_to_watchdog |=> wdt_cnt == CNT_ZERO && pre_cnt == '0)
    else $error("clear did not zero the watchdog");

  a_sleep_zeroes: assert property (@(posedge core_clk) disable iff (reset)
    state == rdw_pkg::ST_RUN && core_op.sleep_instruction && !wdt_expire && pin_level
    |=> wdt_cnt == CNT_ZERO && state == rdw_pkg::ST_SLEEP)
    else $error("sleep did not zero the watchdog");

  a_prescale_steps: assert property (@(posedge core_clk) disable iff (reset)
    wdt_run && !wdt_clear && !wdt_expire && rc_tick && option.prescaler_to_watchdog &&
    (pre_cnt & ratio_mask(option.ratio_sel)) != ratio_mask(option.ratio_sel) |=> $stable(wdt_cnt))
    else $error("watchdog stepped between prescaler outputs");

  // the rc stand-in must keep its period through sleep and core resets
  a_rc_tick_period: assert property (@(posedge core_clk) disable iff (reset)
    rc_tick |-> ##TICK_GAP rc_tick)
    else $error("rc tick period broken");

  a_sleep_counts: assert property (@(posedge core_clk) disable iff (reset)
    state == rdw_pkg::ST_SLEEP && watchdog_enable_fuse && base_tick && !wdt_expire
    |=> wdt_cnt == $past(wdt_cnt) + CNT_ONE)
    else $error("watchdog stalled in sleep");

  a_flag_only_expire: assert property (@(posedge core_clk) disable iff (reset)
    $fell(timeout_flag_n) |-> $past(wdt_expire))
    else $error("time-out flag cleared without a time-out");

  // wake pulses only count in sleep; a running core ignores them
  a_run_ignores_wake: assert property (@(posedge core_clk) disable iff (reset)
    state == rdw_pkg::ST_RUN && pin_level && !wdt_expire && !core_op.sleep_instruction
    |=> state == rdw_pkg::ST_RUN)
    else $error("wake pulse left the run state");

  a_sleep_needs_source: assert property (@(posedge core_clk) disable iff (reset)
    state == rdw_pkg::ST_SLEEP && pin_level && !wdt_expire && !wake_pin_change && !wake_comparator_change
    |=> state == rdw_pkg::ST_SLEEP)
    else $error("sleep left without a wake source");
endmodule

//--- shared/rdw_pkg.sv
// shared constants and types for the reset hold-off timer and watchdog
package rdw_pkg;
  localparam int CLK_NS     = 25;
  // stand-in period of the on-chip rc oscillators, made from core_clk
  localparam int RC_TICK_NS = 250;

  function automatic int ceil_div(input int a, input int b);
    return (a + b - 1) / b;
  endfunction

  localparam int RC_TICK_CYC = ceil_div(RC_TICK_NS, CLK_NS);
  localparam int DIV_W       = 4;

  localparam int HOLD_LONG_NS  = 18_000_000;
  localparam int HOLD_POR_NS   = 1_125_000;
  localparam int HOLD_SHORT_NS = 10_000;
  localparam int WDT_BASE_NS   = 18_000_000;

  localparam int HOLD_LONG_TICKS  = ceil_div(HOLD_LONG_NS, RC_TICK_NS);
  localparam int HOLD_POR_TICKS   = ceil_div(HOLD_POR_NS, RC_TICK_NS);
  localparam int HOLD_SHORT_TICKS = ceil_div(HOLD_SHORT_NS, RC_TICK_NS);
  localparam int WDT_BASE_TICKS   = ceil_div(WDT_BASE_NS, RC_TICK_NS);

  localparam int CNT_W = 17;
  localparam int PS_W  = 3;
  localparam int PRE_W = 7;

  localparam logic PIN_LEVEL_RST    = 1'b1;
  localparam logic TIMEOUT_FLAG_RST = 1'b1;
  localparam logic POR_PEND_RST     = 1'b1;

  typedef enum logic [2:0] {
    OSC_FAST_CRYSTAL     = 3'h0,
    OSC_STANDARD_CRYSTAL = 3'h1,
    OSC_LOW_POWER_CRYSTAL = 3'h2,
    OSC_EXTERNAL_CLOCK   = 3'h3,
    OSC_INTERNAL_OSC     = 3'h4,
    OSC_EXTERNAL_RC      = 3'h5
  } rdw_osc_t;

  // gray along hold -> run -> sleep
  typedef enum logic [1:0] {
    ST_HOLD  = 2'h0,
    ST_RUN   = 2'h1,
    ST_SLEEP = 2'h3,
    ST_PIN   = 2'h2
  } rdw_state_t;

  typedef struct packed {
    logic            prescaler_to_watchdog;
    logic [PS_W-1:0] ratio_sel;
  } rdw_option_t;

  typedef struct packed {
    logic clear_watchdog_instruction;
    logic sleep_instruction;
  } rdw_core_op_t;
endpackage

//--- tb/rdw_core_model.sv
// processor core model: issues clear and sleep operations only while it runs
`timescale 1ns/100ps
module rdw_core_model (
  input  wire logic                  core_reset,
  input  wire logic                  sleep_active,
  input  wire rdw_pkg::rdw_core_op_t req,
  output rdw_pkg::rdw_core_op_t      core_op
);
  // a core held in reset or asleep fetches nothing, so no operation can leak out
  assign core_op = (core_reset || sleep_active) ? '0 : req;
endmodule

//--- tb/testbench.sv
// self-checking bench for the reset hold-off timer and watchdog
`timescale 1ns/100ps
module testbench;
  logic                  core_clk;
  logic                  reset;
  logic                  external_reset_pin;
  rdw_pkg::rdw_osc_t     osc_mode;
  logic                  watchdog_enable_fuse;
  rdw_pkg::rdw_option_t  option;
  rdw_pkg::rdw_core_op_t req;
  rdw_pkg::rdw_core_op_t core_op;
  logic                  wake_pin_change;
  logic                  wake_comparator_change;
  logic                  core_reset;
  logic                  sleep_active;
  logic                  timeout_flag_n;
  int                    error_cnt;
  int                    checks;

  // shortened counts in rc ticks of 10 clocks: long 40, power-on 20, short 4, watchdog 30
  rdw_top #(.HOLD_LONG_TICKS(40), .HOLD_POR_TICKS(20), .HOLD_SHORT_TICKS(4), .WDT_BASE_TICKS(30)) rdw_top_i (
    .core_clk(core_clk), .reset(reset), .external_reset_pin(external_reset_pin), .osc_mode(osc_mode),
    .watchdog_enable_fuse(watchdog_enable_fuse), .option(option), .core_op(core_op),
    .wake_pin_change(wake_pin_change), .wake_comparator_change(wake_comparator_change),
    .core_reset(core_reset), .sleep_active(sleep_active), .timeout_flag_n(timeout_flag_n));
  rdw_core_model rdw_core_model_i (.core_reset(core_reset), .sleep_active(sleep_active), .req(req), .core_op(core_op));

  always #12.5 core_clk = ~core_clk;

  task automatic finish_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string nm);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // counts falling edges until core_reset reaches lvl; the count must fall in lo..hi
  task automatic wt(input logic lvl, input int lo, input int hi, input string nm);
    int n;
    n = 0;
    while (core_reset !== lvl && n <= hi) begin
      @(negedge core_clk);
      n++;
    end
    checks++;
    if (n < lo || n > hi) begin
      error_cnt++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, n);
    end
  endtask

  task automatic op(input logic clr, input logic slp);
    @(negedge core_clk);
    req = '{clear_watchdog_instruction: clr, sleep_instruction: slp};
    @(negedge core_clk);
    req = '0;
  endtask

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    external_reset_pin = 1'b1;
    osc_mode = rdw_pkg::OSC_EXTERNAL_CLOCK;
    watchdog_enable_fuse = 1'b1;
    option = '0;
    req = '0;
    wake_pin_change = 1'b0;
    wake_comparator_change = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    wt(1'b0, 190, 212, "power_on_hold");
    chk(timeout_flag_n, 1'b1, "flag_after_por");
    wt(1'b1, 290, 312, "watchdog_run_timeout");
    chk(timeout_flag_n, 1'b0, "flag_after_timeout");
    wt(1'b0, 30, 56, "hold_after_timeout");
    repeat (5) begin
      repeat (200) @(negedge core_clk);
      op(1'b1, 1'b0);
    end
    chk(core_reset, 1'b0, "alive_with_clears");
    chk(timeout_flag_n, 1'b1, "flag_set_by_clear");
    wt(1'b1, 288, 312, "timeout_after_clear");
    wt(1'b0, 30, 56, "hold_b");
    option = '{prescaler_to_watchdog: 1'b1, ratio_sel: 3'h2};
    // let the prescaler run two ticks so the clear has something to zero
    repeat (25) @(negedge core_clk);
    op(1'b1, 1'b0);
    wt(1'b1, 1185, 1215, "prescaled_timeout");
    wt(1'b0, 30, 56, "hold_c");
    option = '{prescaler_to_watchdog: 1'b0, ratio_sel: 3'h7};
    wt(1'b1, 288, 312, "unassigned_timeout");
    wt(1'b0, 30, 56, "hold_d");
    // a part-way count makes the sleep clear visible in the sleep time-out
    repeat (200) @(negedge core_clk);
    op(1'b0, 1'b1);
    chk(sleep_active, 1'b1, "sleep_entered");
    wt(1'b1, 286, 312, "sleep_timeout");
    chk(timeout_flag_n, 1'b0, "flag_sleep_timeout");
    wt(1'b0, 30, 56, "hold_after_sleep");
    wake_pin_change = 1'b1;
    @(negedge core_clk);
    wake_pin_change = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(core_reset, 1'b0, "wake_ignored_in_run");
    for (int k = 0; k < 2; k++) begin
      op(1'b0, 1'b1);
      repeat (50) @(negedge core_clk);
      wake_pin_change = (k == 0);
      wake_comparator_change = (k == 1);
      @(negedge core_clk);
      wake_pin_change = 1'b0;
      wake_comparator_change = 1'b0;
      wt(1'b1, 0, 3, "wake_reset");
      chk(sleep_active, 1'b0, "sleep_left");
      wt(1'b0, 30, 56, "wake_hold");
    end
    // every oscillator mode: crystal modes hold long, others short after a pin reset
    for (int m = 0; m < 6; m++) begin
      osc_mode = rdw_pkg::rdw_osc_t'(m[2:0]);
      external_reset_pin = 1'b0;
      wt(1'b1, 2, 6, "pin_reset");
      repeat (30) @(negedge core_clk);
      chk(core_reset, 1'b1, "pin_low_hold");
      external_reset_pin = 1'b1;
      if (m < 3) wt(1'b0, 390, 416, "crystal_hold");
      else wt(1'b0, 30, 56, "short_hold");
    end
    watchdog_enable_fuse = 1'b0;
    repeat (700) @(negedge core_clk);
    chk(core_reset, 1'b0, "fuse_disabled");
    // a second power-on reset must bring back the power-on first hold-off
    reset = 1'b1;
    repeat (5) @(negedge core_clk);
    chk(core_reset, 1'b1, "core_in_reset");
    chk(sleep_active, 1'b0, "sleep_in_reset");
    reset = 1'b0;
    wt(1'b0, 190, 212, "second_power_on");
    finish_test();
  end

  // the sequence needs about 6700 clocks of 25 ns
  initial begin
    #1ms;
    error_cnt++;
    finish_test();
  end
endmodule
